// File: common/peripheral_clock_gate_pkg.sv
// constants shared by the clock gate bank and its helpers
package peripheral_clock_gate_pkg;

	// register decode, byte addresses
	localparam int unsigned DECODE_W = 13;
	localparam logic [12:0] GATE_SIX_OFFSET = 13'h103c;
	localparam logic [12:0] GATE_STATUS_OFFSET = 13'h1100;

	// gate bit positions in peripheral_clock_gate_six
	localparam int unsigned RTC_ACCESS_BIT = 29;
	localparam int unsigned CONVERTER_ZERO_BIT = 27;
	localparam int unsigned TIMER_PWM_TWO_BIT = 26;
	localparam int unsigned TIMER_PWM_ONE_BIT = 25;
	localparam int unsigned TIMER_PWM_ZERO_BIT = 24;
	localparam int unsigned PERIODIC_TIMER_BIT = 23;
	localparam int unsigned CRC_UNIT_BIT = 18;
	localparam int unsigned DMA_REQUEST_MUX_BIT = 1;
	localparam int unsigned FLASH_CONTROLLER_BIT = 0;

	// implemented bits and reset value
	localparam logic [31:0] GATE_SIX_WRITE_MASK = 32'h2f84_0003;
	localparam logic [31:0] GATE_SIX_RESET = 32'h0000_0001;

	// gate_status fields
	localparam int unsigned STATUS_REFUSED_BIT = 0;
	localparam int unsigned STATUS_GRANTED_BIT = 1;
	localparam int unsigned STATUS_RTC_DENIED_BIT = 2;
	localparam int unsigned STATUS_COUNT_LSB = 8;
	localparam int unsigned REFUSAL_COUNT_W = 8;

	// ahb transfer encoding
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ = 2'h3;
	localparam logic [2:0] HSIZE_BYTE = 3'h0;
	localparam logic [2:0] HSIZE_HALF = 3'h1;
	localparam logic HRESP_OKAY = 1'b0;

	typedef enum logic [1:0] {
		LP_IDLE = 2'b00,
		LP_REFUSED = 2'b01,
		LP_GRANTED = 2'b10
	} lp_state_e;

endpackage

// File: verilog/lowpower_gatekeeper.sv
// low-power entry arbiter held off while the flash clock is gated
`timescale 1ns/1ps
module lowpower_gatekeeper #(
	parameter int unsigned COUNT_W = 8
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic lp_entry_req_i,
	input wire logic flash_gate_i,
	output logic lp_entry_grant_o,
	output logic lp_entry_refused_o,
	output logic [COUNT_W-1:0] refusal_count_o
);

	peripheral_clock_gate_pkg::lp_state_e state;
	peripheral_clock_gate_pkg::lp_state_e next_state;
	logic [COUNT_W-1:0] next_count;
	logic refusal_start;
	logic count_full;

	always_comb begin
		next_state = state;
		case (state)
			peripheral_clock_gate_pkg::LP_IDLE: begin
				if (lp_entry_req_i && flash_gate_i) begin
					next_state = peripheral_clock_gate_pkg::LP_GRANTED;
				end else if (lp_entry_req_i) begin
					next_state = peripheral_clock_gate_pkg::LP_REFUSED;
				end
			end
			peripheral_clock_gate_pkg::LP_REFUSED: begin
				if (!lp_entry_req_i) begin
					next_state = peripheral_clock_gate_pkg::LP_IDLE;
				end else if (flash_gate_i) begin
					next_state = peripheral_clock_gate_pkg::LP_GRANTED;
				end
			end
			peripheral_clock_gate_pkg::LP_GRANTED: begin
				if (!lp_entry_req_i) begin
					next_state = peripheral_clock_gate_pkg::LP_IDLE;
				end else if (!flash_gate_i) begin
					next_state = peripheral_clock_gate_pkg::LP_REFUSED;
				end
			end
			default: begin
				next_state = peripheral_clock_gate_pkg::LP_IDLE;
			end
		endcase
	end

	assign refusal_start = (next_state == peripheral_clock_gate_pkg::LP_REFUSED) &&
		(state != peripheral_clock_gate_pkg::LP_REFUSED);
	assign count_full = &refusal_count_o;
	assign next_count = (refusal_start && !count_full) ? refusal_count_o + 1'b1 : refusal_count_o;

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state <= peripheral_clock_gate_pkg::LP_IDLE;
			refusal_count_o <= '0;
		end else begin
			state <= next_state;
			refusal_count_o <= next_count;
		end
	end

	// grant only while the flash clock runs
	assign lp_entry_grant_o = (state == peripheral_clock_gate_pkg::LP_GRANTED) && flash_gate_i;
	assign lp_entry_refused_o = (state == peripheral_clock_gate_pkg::LP_REFUSED);

endmodule

// File: verilog/rtc_access_filter.sv
// gates software access and interrupts of the real-time clock unit
`timescale 1ns/1ps
module rtc_access_filter (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic rtc_enable_i,
	input wire logic rtc_access_req_i,
	input wire logic rtc_irq_i,
	output logic rtc_access_req_o,
	output logic rtc_access_denied_o,
	output logic rtc_irq_o
);

	logic next_denied;

	assign rtc_access_req_o = rtc_access_req_i && rtc_enable_i;
	assign rtc_irq_o = rtc_irq_i && rtc_enable_i;
	assign next_denied = rtc_access_req_i && !rtc_enable_i;

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rtc_access_denied_o <= 1'b0;
		end else begin
			rtc_access_denied_o <= next_denied;
		end
	end

endmodule

// File: verilog/peripheral_clock_gate_bank_six.sv
// peripheral clock gate register six with ahb-lite slave port
//
// How it works
// - bit 29 enables rtc access and interrupts
// - bit 27 gates converter zero clock
// - bit 26 gates timer pwm two clock
// - bit 25 gates timer pwm one clock
// - bit 24 gates timer pwm zero clock
// - bit 23 gates periodic timer clock
// - bit 18 gates crc unit clock
// - bit 1 gates dma request mux clock
// - bit 0 gates flash controller clock
// - flash reads complete while flash gated
// - low-power entry refused while flash gated
// - reserved bits read zero, ignore writes
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/1ps
module peripheral_clock_gate_bank_six (
	input wire logic core_clk_i,
	input wire logic rst_i,

	// ahb-lite slave
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic hreadyout_o,
	output logic hresp_o,
	output logic [31:0] hrdata_o,

	// gate enables
	output logic converter_zero_gate_o,
	output logic timer_pwm_two_gate_o,
	output logic timer_pwm_one_gate_o,
	output logic timer_pwm_zero_gate_o,
	output logic periodic_timer_gate_o,
	output logic crc_unit_gate_o,
	output logic dma_request_mux_gate_o,
	output logic flash_controller_gate_o,

	// flash read path
	input wire logic flash_rd_req_i,
	output logic flash_rd_req_o,
	output logic flash_core_clk_en_o,

	// low-power entry handshake
	input wire logic lp_entry_req_i,
	output logic lp_entry_grant_o,
	output logic lp_entry_refused_o,

	// real-time clock unit
	output logic rtc_enable_o,
	input wire logic rtc_access_req_i,
	input wire logic rtc_irq_i,
	output logic rtc_access_req_o,
	output logic rtc_irq_o
);

	localparam int unsigned CW = peripheral_clock_gate_pkg::REFUSAL_COUNT_W;

	// stored register
	logic [31:0] gate_six;
	logic [31:0] next_gate_six;

	// address phase capture
	logic addr_valid;
	logic addr_write;
	logic addr_hit_six;
	logic addr_hit_status;
	logic [31:0] addr_lanes;

	// decode of the current address phase
	logic trans_active;
	logic trans_take;
	logic [12:0] decode_addr;
	logic dec_hit_six;
	logic dec_hit_status;
	logic [3:0] byte_strobe;
	logic [31:0] lane_mask;

	// write commit in the data phase
	logic write_six;
	logic [31:0] write_bits;
	logic [31:0] merged_six;

	// read path
	logic [31:0] visible_six;
	logic [31:0] status_word;
	logic [31:0] next_rdata;

	// helper state
	logic lp_refused;
	logic lp_granted;
	logic rtc_denied;
	logic rtc_denied_seen;
	logic next_rtc_denied_seen;
	logic status_clear;
	logic [CW-1:0] refusal_count;

	assign trans_active = (htrans_i == peripheral_clock_gate_pkg::HTRANS_NONSEQ) ||
		(htrans_i == peripheral_clock_gate_pkg::HTRANS_SEQ);
	assign trans_take = hsel_i && hready_i && trans_active;
	assign decode_addr = haddr_i[12:0];
	assign dec_hit_six = (decode_addr == peripheral_clock_gate_pkg::GATE_SIX_OFFSET);
	assign dec_hit_status = (decode_addr == peripheral_clock_gate_pkg::GATE_STATUS_OFFSET);

	// byte lanes from size and low address bits
	always_comb begin
		byte_strobe = 4'hf;
		case (hsize_i)
			peripheral_clock_gate_pkg::HSIZE_BYTE: begin
				byte_strobe = 4'h1 << haddr_i[1:0];
			end
			peripheral_clock_gate_pkg::HSIZE_HALF: begin
				byte_strobe = haddr_i[1] ? 4'hc : 4'h3;
			end
			default: begin
				byte_strobe = 4'hf;
			end
		endcase
	end

	genvar lane;
	generate
		for (lane = 0; lane < 4; lane++) begin : g_lane
			assign lane_mask[lane*8 +: 8] = {8{byte_strobe[lane]}};
		end
	endgenerate

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			addr_valid <= 1'b0;
			addr_write <= 1'b0;
			addr_hit_six <= 1'b0;
			addr_hit_status <= 1'b0;
			addr_lanes <= 32'h0000_0000;
		end else if (hready_i) begin
			addr_valid <= trans_take;
			addr_write <= hwrite_i;
			addr_hit_six <= dec_hit_six;
			addr_hit_status <= dec_hit_status;
			addr_lanes <= lane_mask;
		end
	end

	// data phase write, only implemented bits take the value
	assign write_six = addr_valid && addr_write && addr_hit_six;
	assign write_bits = addr_lanes & peripheral_clock_gate_pkg::GATE_SIX_WRITE_MASK;
	assign merged_six = (gate_six & ~write_bits) | (hwdata_i & write_bits);
	assign next_gate_six = write_six ? merged_six : gate_six;

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			gate_six <= peripheral_clock_gate_pkg::GATE_SIX_RESET;
		end else begin
			gate_six <= next_gate_six;
		end
	end

	// status word, write one to bit 2 clears the denied flag
	assign status_clear = addr_valid && addr_write && addr_hit_status &&
		hwdata_i[peripheral_clock_gate_pkg::STATUS_RTC_DENIED_BIT] &&
		addr_lanes[peripheral_clock_gate_pkg::STATUS_RTC_DENIED_BIT];
	// a new denial wins over a clear in the same cycle
	assign next_rtc_denied_seen = rtc_denied || (rtc_denied_seen && !status_clear);

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rtc_denied_seen <= 1'b0;
		end else begin
			rtc_denied_seen <= next_rtc_denied_seen;
		end
	end

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[peripheral_clock_gate_pkg::STATUS_REFUSED_BIT] = lp_refused;
		status_word[peripheral_clock_gate_pkg::STATUS_GRANTED_BIT] = lp_granted;
		status_word[peripheral_clock_gate_pkg::STATUS_RTC_DENIED_BIT] = rtc_denied_seen;
		status_word[peripheral_clock_gate_pkg::STATUS_COUNT_LSB +: CW] = refusal_count;
	end

	// forward a write still in its data phase to a read right behind it
	assign visible_six = next_gate_six & peripheral_clock_gate_pkg::GATE_SIX_WRITE_MASK;

	always_comb begin
		next_rdata = 32'h0000_0000;
		if (trans_take && !hwrite_i && dec_hit_six) begin
			next_rdata = visible_six;
		end else if (trans_take && !hwrite_i && dec_hit_status) begin
			next_rdata = status_word;
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			hrdata_o <= 32'h0000_0000;
		end else if (hready_i) begin
			hrdata_o <= next_rdata;
		end
	end

	// zero wait states, always okay
	assign hreadyout_o = 1'b1;
	assign hresp_o = peripheral_clock_gate_pkg::HRESP_OKAY;

	// gate outputs straight from the stored bits
	assign converter_zero_gate_o = gate_six[peripheral_clock_gate_pkg::CONVERTER_ZERO_BIT];
	assign timer_pwm_two_gate_o = gate_six[peripheral_clock_gate_pkg::TIMER_PWM_TWO_BIT];
	assign timer_pwm_one_gate_o = gate_six[peripheral_clock_gate_pkg::TIMER_PWM_ONE_BIT];
	assign timer_pwm_zero_gate_o = gate_six[peripheral_clock_gate_pkg::TIMER_PWM_ZERO_BIT];
	assign periodic_timer_gate_o = gate_six[peripheral_clock_gate_pkg::PERIODIC_TIMER_BIT];
	assign crc_unit_gate_o = gate_six[peripheral_clock_gate_pkg::CRC_UNIT_BIT];
	assign dma_request_mux_gate_o = gate_six[peripheral_clock_gate_pkg::DMA_REQUEST_MUX_BIT];
	assign flash_controller_gate_o = gate_six[peripheral_clock_gate_pkg::FLASH_CONTROLLER_BIT];
	assign rtc_enable_o = gate_six[peripheral_clock_gate_pkg::RTC_ACCESS_BIT];

	// flash read path stays clocked whenever a read is pending
	assign flash_rd_req_o = flash_rd_req_i;
	assign flash_core_clk_en_o = flash_controller_gate_o || flash_rd_req_i;

	lowpower_gatekeeper #(
		.COUNT_W(CW)
	) u_gatekeeper (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.lp_entry_req_i(lp_entry_req_i),
		.flash_gate_i(flash_controller_gate_o),
		.lp_entry_grant_o(lp_granted),
		.lp_entry_refused_o(lp_refused),
		.refusal_count_o(refusal_count)
	);

	assign lp_entry_grant_o = lp_granted;
	assign lp_entry_refused_o = lp_refused;

	rtc_access_filter u_rtc_filter (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.rtc_enable_i(rtc_enable_o),
		.rtc_access_req_i(rtc_access_req_i),
		.rtc_irq_i(rtc_irq_i),
		.rtc_access_req_o(rtc_access_req_o),
		.rtc_access_denied_o(rtc_denied),
		.rtc_irq_o(rtc_irq_o)
	);

endmodule

// File: testbench/peripheral_clock_gate_bank_six_properties.sv
// port assertions for the clock gate bank
`timescale 1ns/1ps
module peripheral_clock_gate_bank_six_checker (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic flash_controller_gate_o,
	input wire logic flash_rd_req_i,
	input wire logic flash_rd_req_o,
	input wire logic flash_core_clk_en_o,
	input wire logic lp_entry_req_i,
	input wire logic lp_entry_grant_o,
	input wire logic lp_entry_refused_o,
	input wire logic rtc_enable_o,
	input wire logic rtc_access_req_i,
	input wire logic rtc_irq_i,
	input wire logic rtc_access_req_o,
	input wire logic rtc_irq_o
);
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (rst_i);
	chk_flash_read_pass: assert property (flash_rd_req_o == flash_rd_req_i)
		else $error("flash read request altered");
	chk_flash_clk_on: assert property (
		flash_core_clk_en_o == (flash_controller_gate_o | flash_rd_req_i))
		else $error("flash clock enable wrong");
	chk_rtc_access: assert property (
		rtc_access_req_o == (rtc_access_req_i & rtc_enable_o))
		else $error("rtc access gating wrong");
	chk_rtc_irq: assert property (rtc_irq_o == (rtc_irq_i & rtc_enable_o))
		else $error("rtc interrupt gating wrong");
	chk_grant_needs_flash: assert property (lp_entry_grant_o |-> flash_controller_gate_o)
		else $error("low-power granted with flash gated");
	chk_refuse_entry: assert property (
		lp_entry_req_i && !flash_controller_gate_o |=> lp_entry_refused_o && !lp_entry_grant_o)
		else $error("low-power entry not refused");
	chk_grant_entry: assert property (
		lp_entry_req_i && flash_controller_gate_o |=> lp_entry_grant_o || !flash_controller_gate_o)
		else $error("low-power entry not granted");
	chk_idle_no_req: assert property (
		!lp_entry_req_i |=> !lp_entry_grant_o && !lp_entry_refused_o)
		else $error("low-power answer without request");
endmodule

bind peripheral_clock_gate_bank_six peripheral_clock_gate_bank_six_checker chk (
	.core_clk_i, .rst_i, .flash_controller_gate_o, .flash_rd_req_i, .flash_rd_req_o,
	.flash_core_clk_en_o, .lp_entry_req_i, .lp_entry_grant_o, .lp_entry_refused_o,
	.rtc_enable_o, .rtc_access_req_i, .rtc_irq_i, .rtc_access_req_o, .rtc_irq_o
);

// File: testbench/peripheral_clock_gate_bank_six_tb.sv
// self-checking bench for the clock gate bank
`timescale 1ns/1ps
module peripheral_clock_gate_bank_six_tb;
	logic core_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic hsel_i = 1'b0;
	logic hwrite_i = 1'b0;
	logic [1:0] htrans_i = 2'h0;
	logic [2:0] hsize_i = 3'h2;
	logic [31:0] haddr_i = 32'h0;
	logic [31:0] hwdata_i = 32'h0;
	logic [31:0] hrdata_o, v, w;
	logic [31:0] m = 32'h1;
	logic [8:0] g;
	logic [1:0] lps = 2'h0;
	logic hreadyout_o, hresp_o, fl_o, fl_en, gr, rf, rt_o, irq_o;
	logic lp_req = 1'b0, fl_req = 1'b0, rt_req = 1'b0, rt_irq = 1'b0;
	int n_errors = 0, n_checks = 0, cyc = 0, cnt = 0;
	logic [31:0] st_now = 32'h0, st_last = 32'h0;
	logic dn = 1'b0, dp = 1'b0;

	peripheral_clock_gate_bank_six uut (
		.core_clk_i(core_clk_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
		.htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
		.hready_i(hreadyout_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
		.hrdata_o(hrdata_o), .converter_zero_gate_o(g[7]), .timer_pwm_two_gate_o(g[6]),
		.timer_pwm_one_gate_o(g[5]), .timer_pwm_zero_gate_o(g[4]),
		.periodic_timer_gate_o(g[3]), .crc_unit_gate_o(g[2]),
		.dma_request_mux_gate_o(g[1]), .flash_controller_gate_o(g[0]),
		.flash_rd_req_i(fl_req), .flash_rd_req_o(fl_o), .flash_core_clk_en_o(fl_en),
		.lp_entry_req_i(lp_req), .lp_entry_grant_o(gr), .lp_entry_refused_o(rf),
		.rtc_enable_o(g[8]), .rtc_access_req_i(rt_req), .rtc_irq_i(rt_irq),
		.rtc_access_req_o(rt_o), .rtc_irq_o(irq_o)
	);

	initial begin
		forever #25 core_clk_i = ~core_clk_i;
	end

	task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic complete_run;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// one single word transfer, waits on hready in both phases
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] r);
		hsel_i <= 1'b1;
		haddr_i <= a;
		hwrite_i <= wr;
		htrans_i <= 2'h2;
		do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
		htrans_i <= 2'h0;
		hwdata_i <= d;
		do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
		r = hrdata_o;
	endtask

	// side inputs wander; low-power request held for several cycles
	always @(posedge core_clk_i) begin
		fl_req <= 1'($urandom);
		rt_req <= 1'($urandom);
		rt_irq <= 1'($urandom);
		lp_req <= ($urandom_range(7) == 0) ? ~lp_req : lp_req;
	end

	// cycle model of gates and low-power state, compared mid-cycle
	always @(negedge core_clk_i) begin
		if (!rst_i) begin
			check("gates", {23'h0, g}, {23'h0, m[29], m[27:23], m[18], m[1:0]});
			check("side", {24'h0, hreadyout_o, hresp_o, fl_o, fl_en, gr, rf, rt_o, irq_o},
				{24'h0, 1'b1, 1'b0, fl_req, fl_req | m[0], lps == 2'h2 && m[0], lps == 2'h1,
				rt_req & m[29], rt_irq & m[29]});
			// status as the design holds it now, and one cycle earlier
			st_last = st_now;
			st_now = {16'h0, cnt[7:0], 5'h0, dn, lps == 2'h2 && m[0], lps == 2'h1};
			// denial lands in the sticky flag two edges after it is sampled
			dn = dn | dp;
			dp = rt_req & ~m[29];
			if (lp_req && !m[0] && lps != 2'h1 && cnt < 255) begin
				cnt++;
			end
			lps = !lp_req ? 2'h0 : (m[0] ? 2'h2 : 2'h1);
		end else begin
			lps = 2'h0;
			dn = 1'b0;
			dp = 1'b0;
			cnt = 0;
		end
	end

	always @(posedge core_clk_i) begin
		cyc++;
		if (cyc > 3000) begin
			n_errors++;
			complete_run();
		end
	end

	initial begin
		void'($urandom(45946));
		repeat (8) @(posedge core_clk_i);
		rst_i <= 1'b0;
		bus(1'b0, 32'h103c, 32'h0, v);
		check("reset value", v, 32'h1);
		for (int i = 0; i < 40; i++) begin
			w = (i == 0) ? 32'hffff_ffff : ((i == 1) ? 32'h0 : $urandom);
			bus(1'b1, 32'h103c, w, v);
			m = w & 32'h2f84_0003;
			bus(1'b0, 32'h103c, 32'h0, v);
			check("readback", v, m);
			bus(1'b0, 32'h1100, 32'h0, v);
			check("status", v, st_last);
			repeat ($urandom_range(6)) @(posedge core_clk_i);
		end
		bus(1'b1, 32'h1004, 32'hffff_ffff, v);
		bus(1'b0, 32'h1004, 32'h0, v);
		check("unmapped", v, 32'h0);
		rst_i <= 1'b1;
		m = 32'h1;
		repeat (2) @(posedge core_clk_i);
		rst_i <= 1'b0;
		bus(1'b0, 32'h103c, 32'h0, v);
		check("second reset", v, 32'h1);
		complete_run();
	end
endmodule
